// [core/ccd_pkg.sv]
// Package: widths, reset values and phase encoding for the cascaded duty-correcting divider
package ccd_pkg;

  localparam int unsigned CCD_CNT_W   = 4;
  localparam int unsigned CCD_STG_W   = 5;
  localparam int unsigned CCD_RATIO_W = 10;
  localparam int unsigned CCD_NSTG    = 2;

  localparam logic [CCD_CNT_W-1:0]   CCD_CNT_RST   = 4'h0;
  localparam logic [CCD_RATIO_W-1:0] CCD_RATIO_RST = 10'h001;
  localparam logic                   CCD_OUT_RST   = 1'b0;
  localparam logic                   CCD_OK_RST    = 1'b1;

  typedef enum logic [1:0] {
    CCD_PH_HIGH = 2'b01,
    CCD_PH_LOW  = 2'b10
  } ccd_phase_e;

endpackage

// [core/ccd_divider.sv]
// Two cascaded high/low counting dividers with optional half-cycle duty correction

// ************************************************************
// Behaviour
// ************************************************************
// Behaviour
// - Correction off, both bypassed: input duty passes, whatever its value.
// - Correction off: high fraction is (N+1)/(N+M+2) of last active stage.
// - Correction off, raw input, both bypassed: input duty reproduced unchanged.
// - Correction on, 50% input, legal counts: output duty is 50%.
// - Correction on, both bypassed: input duty passes through unaltered.
// - Correction on: an even active stage with equal high and low counts yields 50%.
// - Correction on, all odd: duty departs slightly from 50% when the input duty is not 50%.
// - Fields hold cycle count minus one; stage ratio is high plus low plus two.
// - Channel ratio is 1, either stage ratio alone, or product of both ratios.
module ccd_divider
  import ccd_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   clk_in,
  input  wire logic [CCD_CNT_W-1:0]   high_cnt_1,
  input  wire logic [CCD_CNT_W-1:0]   low_cnt_1,
  input  wire logic [CCD_CNT_W-1:0]   high_cnt_2,
  input  wire logic [CCD_CNT_W-1:0]   low_cnt_2,
  input  wire logic                   bypass_1,
  input  wire logic                   bypass_2,
  input  wire logic                   duty_correction_disable,
  output logic                        clk_out,
  output logic [CCD_RATIO_W-1:0]      ratio,
  output logic                        config_ok
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [CCD_STG_W-1:0] stg_ratio(input logic [CCD_CNT_W-1:0] hi,
                                                     input logic [CCD_CNT_W-1:0] lo);
    stg_ratio = {1'b0, hi} + {1'b0, lo} + 5'h02;
  endfunction

  function automatic logic stg_odd(input logic [CCD_CNT_W-1:0] hi, input logic [CCD_CNT_W-1:0] lo);
    stg_odd = hi[0] ^ lo[0];
  endfunction

  // Widened compare, so a high count of 15 cannot wrap onto a low count of 0
  function automatic logic stg_legal(input logic [CCD_CNT_W-1:0] hi, input logic [CCD_CNT_W-1:0] lo);
    stg_legal = stg_odd(hi, lo) ? ({1'b0, lo} == {1'b0, hi} + 5'h01) : (lo == hi);
  endfunction

  // ************************************************************
  // Input synchroniser
  // ************************************************************
  logic sync1_r;
  logic sync2_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= clk_in;
      sync2_r <= sync1_r;
    end
  end

  // ************************************************************
  // Stage decode
  // ************************************************************
  logic [CCD_CNT_W-1:0] hi_w  [CCD_NSTG];
  logic [CCD_CNT_W-1:0] lo_w  [CCD_NSTG];
  logic                 in_w  [CCD_NSTG];
  logic                 odd_w [CCD_NSTG];
  logic                 half_en_w [CCD_NSTG];
  logic                 stg_out_r [CCD_NSTG];
  logic                 dcc_on;

  assign dcc_on = ~duty_correction_disable;
  assign hi_w[0] = high_cnt_1;
  assign lo_w[0] = low_cnt_1;
  assign hi_w[1] = high_cnt_2;
  assign lo_w[1] = low_cnt_2;
  assign in_w[0] = sync2_r;
  // Stage two runs from the raw input when stage one is bypassed
  assign in_w[1] = bypass_1 ? sync2_r : stg_out_r[0];

  // ************************************************************
  // Divider stages
  // ************************************************************
  for (genvar g = 0; g < CCD_NSTG; g++) begin : g_stg
    logic                 prev_r;
    logic [CCD_CNT_W-1:0] cnt_r;
    logic [CCD_CNT_W-1:0] cnt_nxt;
    ccd_phase_e           ph_r;
    ccd_phase_e           ph_nxt;
    logic                 half_r;
    logic                 half_nxt;
    logic                 out_nxt;
    logic                 rise;
    logic                 fall;
    logic                 hi_done;
    logic                 lo_done;
    logic                 late_fall;

    assign odd_w[g]     = stg_odd(hi_w[g], lo_w[g]);
    // Odd ratio under correction: drop on the input falling edge, half a cycle late
    assign half_en_w[g] = dcc_on & odd_w[g];
    assign rise    = in_w[g] & ~prev_r;
    assign fall    = ~in_w[g] & prev_r;
    assign hi_done = rise && (ph_r == CCD_PH_HIGH) && (cnt_r == hi_w[g]);
    assign lo_done = rise && (ph_r == CCD_PH_LOW) && (cnt_r == lo_w[g]);
    // Pending late fall lands on the first input fall after the high span
    assign late_fall = half_r & fall;

    // ************************************************************
    // Stage next state
    // ************************************************************
    assign cnt_nxt  = (hi_done || lo_done) ? CCD_CNT_RST :
                      rise                 ? cnt_r + 4'h1 :
                                             cnt_r;
    assign ph_nxt   = hi_done ? CCD_PH_LOW  :
                      lo_done ? CCD_PH_HIGH :
                                ph_r;
    assign half_nxt = lo_done                   ? 1'b0 :
                      (hi_done && half_en_w[g]) ? 1'b1 :
                      late_fall                 ? 1'b0 :
                                                  half_r;
    // Uncorrected stages fall on the counting edge itself
    assign out_nxt  = lo_done                   ? 1'b1 :
                      (hi_done && half_en_w[g]) ? stg_out_r[g] :
                      hi_done                   ? 1'b0 :
                      late_fall                 ? 1'b0 :
                                                  stg_out_r[g];

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        prev_r       <= 1'b0;
        cnt_r        <= CCD_CNT_RST;
        ph_r         <= CCD_PH_LOW;
        half_r       <= 1'b0;
        stg_out_r[g] <= CCD_OUT_RST;
      end else begin
        prev_r       <= in_w[g];
        cnt_r        <= cnt_nxt;
        ph_r         <= ph_nxt;
        half_r       <= half_nxt;
        stg_out_r[g] <= out_nxt;
      end
    end
  end

  // ************************************************************
  // Ratio decode
  // ************************************************************
  logic [CCD_STG_W-1:0]   r1_w;
  logic [CCD_STG_W-1:0]   r2_w;
  logic [CCD_RATIO_W-1:0] prod_w;

  assign r1_w   = stg_ratio(hi_w[0], lo_w[0]);
  assign r2_w   = stg_ratio(hi_w[1], lo_w[1]);
  // Limitation: a stage ratio of 32 needs a sixth bit, so it reads back as zero, and so does any product with it
  assign prod_w = {5'h00, r1_w} * {5'h00, r2_w};

  // ************************************************************
  // Output selection and status
  // ************************************************************
  logic                   sel_w;
  logic [CCD_RATIO_W-1:0] ratio_nxt;
  logic                   ok_nxt;
  logic                   stg_ok_1;
  logic                   stg_ok_2;
  logic                   order_ok;

  // Last active stage drives the output; both bypassed passes the input as is
  assign sel_w = (bypass_1 && bypass_2) ? sync2_r :
                 (bypass_2 ? stg_out_r[0] : stg_out_r[1]);

  assign ratio_nxt = (bypass_1 && bypass_2) ? CCD_RATIO_RST :
                     bypass_2 ? {5'h00, r1_w} :
                     bypass_1 ? {5'h00, r2_w} :
                     prod_w;

  // Flags a setting that breaks the correction conditions; output still runs
  assign stg_ok_1 = bypass_1 || stg_legal(hi_w[0], lo_w[0]);
  assign stg_ok_2 = bypass_2 || stg_legal(hi_w[1], lo_w[1]);
  assign order_ok = !(bypass_1 && !bypass_2) &&
                    !(!bypass_1 && !bypass_2 && !odd_w[0] && odd_w[1]);
  assign ok_nxt   = duty_correction_disable || (stg_ok_1 && stg_ok_2 && order_ok);

  // ************************************************************
  // Output registers
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_out <= CCD_OUT_RST;
    end else begin
      clk_out <= sel_w;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ratio <= CCD_RATIO_RST;
    end else begin
      ratio <= ratio_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      config_ok <= CCD_OK_RST;
    end else begin
      config_ok <= ok_nxt;
    end
  end

endmodule

// [dv/ccd_divider_sva.sv]
// Checker: ratio, config and waveform relations of the cascaded divider
module ccd_divider_sva
  import ccd_pkg::*;
(
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   clk_in,
  input wire logic [CCD_CNT_W-1:0]   high_cnt_1,
  input wire logic [CCD_CNT_W-1:0]   low_cnt_1,
  input wire logic [CCD_CNT_W-1:0]   high_cnt_2,
  input wire logic [CCD_CNT_W-1:0]   low_cnt_2,
  input wire logic                   bypass_1,
  input wire logic                   bypass_2,
  input wire logic                   duty_correction_disable,
  input wire logic                   clk_out,
  input wire logic [CCD_RATIO_W-1:0] ratio,
  input wire logic                   config_ok
);
  // ****
  // Input rises counted while the output is high
  // ****
  logic       in_d_r;
  logic [7:0] hi_r;
  wire        one_st = !bypass_1 && bypass_2;
  wire        dcd    = duty_correction_disable;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_d_r <= 1'b0;
      hi_r   <= 8'h00;
    end else begin
      in_d_r <= clk_in;
      hi_r   <= clk_out ? hi_r + {7'h00, clk_in && !in_d_r} : 8'h00;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_RATIO_BYP: assert property (bypass_1 && bypass_2 |=> ratio == 10'h001)
    else $error("ratio not one with both stages bypassed");
  AST_RATIO_ONE: assert property (one_st |=> ratio == high_cnt_1 + low_cnt_1 + 10'h002)
    else $error("single stage ratio wrong");
  AST_RATIO_PROD: assert property (!bypass_1 && !bypass_2 |=>
    ratio == (high_cnt_1 + low_cnt_1 + 10'h002) * (high_cnt_2 + low_cnt_2 + 10'h002))
    else $error("cascaded ratio wrong");
  AST_OK_BYP: assert property (!dcd && bypass_1 && !bypass_2 |=> !config_ok)
    else $error("lone first bypass accepted");
  AST_BYP_PASS: assert property ((bypass_1 && bypass_2) [*4] |-> clk_out == $past(clk_in, 3))
    else $error("bypass output does not follow input");
  // Span is measured in input rises, so it holds whatever the input duty
  AST_HIGH_SPAN: assert property (!bypass_1 && (dcd || bypass_2) && $fell(clk_out) |-> hi_r ==
    (bypass_2 ? high_cnt_1 + 8'h01 : (high_cnt_2 + 8'h01) * (high_cnt_1 + low_cnt_1 + 8'h02)))
    else $error("high span wrong");
  AST_FALL_ON_RISE: assert property (dcd && one_st && $fell(clk_out) |-> $past(clk_in, 3))
    else $error("uncorrected fall not on input rise");
  AST_LATE_FALL: assert property (!dcd && one_st && (high_cnt_1[0] ^ low_cnt_1[0]) && $fell(clk_out)
    |-> !$past(clk_in, 2))
    else $error("corrected odd fall not on input fall");
  cover property (one_st && $fell(clk_out));
  cover property (!bypass_1 && !bypass_2 && $rose(clk_out));
  cover property (!config_ok);
endmodule

// [dv/ccd_divider_tb_top.sv]
// Testbench: duty, ratio and config scenarios for the cascaded divider
module ccd_divider_tb_top import ccd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Stimulus and checks
  // ****
  logic                   clk_sys = 1'b0, rst = 1'b1, clk_in = 1'b0, b1 = 1'b1, b2 = 1'b1, dcd = 1'b1;
  logic [CCD_CNT_W-1:0]   h1 = 4'h0, l1 = 4'h0, h2 = 4'h0, l2 = 4'h0;
  logic                   clk_out, ok;
  logic [CCD_RATIO_W-1:0] ratio;
  logic [15:0]            hi, lo;
  int                     n_mismatch = 0, checks_done = 0, in_hi = 4, in_lo = 4;
  ccd_divider uut (.clk_sys(clk_sys), .rst(rst), .clk_in(clk_in), .high_cnt_1(h1), .low_cnt_1(l1),
    .high_cnt_2(h2), .low_cnt_2(l2), .bypass_1(b1), .bypass_2(b2), .duty_correction_disable(dcd),
    .clk_out(clk_out), .ratio(ratio), .config_ok(ok));
  initial forever #2 clk_sys = ~clk_sys;
  // Input clock is far slower than the sampling clock, as the synchroniser needs
  initial forever begin
    repeat (in_lo) @(negedge clk_sys);
    clk_in = 1'b1;
    repeat (in_hi) @(negedge clk_sys);
    clk_in = 1'b0;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Config changes only under reset, so no transient period is measured
  task automatic setup(input logic a, b, d, input logic [3:0] n1, m1, n2, m2, input int ih, il);
    @(negedge clk_sys);
    {rst, b1, b2, dcd, h1, l1, h2, l2, in_hi, in_lo} = {1'b1, a, b, d, n1, m1, n2, m2, ih, il};
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
  endtask
  task automatic meas();
    int k;
    k = 0;
    while (clk_out !== 1'b1 && k < 300) begin @(negedge clk_sys); k++; end
    for (hi = 0; clk_out === 1'b1 && hi < 300; hi++) @(negedge clk_sys);
    for (lo = 0; clk_out !== 1'b1 && lo < 300; lo++) @(negedge clk_sys);
    if (k >= 300 || hi >= 300 || lo >= 300) begin chk(16'h0001, 16'h0000); final_report(); end
  endtask
  task automatic t_bypass(input logic d);
    setup(1, 1, d, 0, 0, 0, 0, 3, 5);
    meas();
    chk(hi, 16'h0003);
    chk(lo, 16'h0005);
    chk({6'h00, ratio}, 16'h0001);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  task automatic t_single(input logic d, input logic [15:0] eh, el);
    setup(0, 1, d, 1, 2, 0, 0, 4, 4);
    meas();
    chk(hi, eh);
    chk(lo, el);
    chk({6'h00, ratio}, 16'h0005);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  task automatic t_cascade(input logic d, input logic [3:0] n1, m1, n2, m2, input logic [15:0] eh, el);
    setup(0, 0, d, n1, m1, n2, m2, 3, 5);
    meas();
    chk(hi, eh);
    chk(lo, el);
    chk({6'h00, ratio}, 16'h000A);
  endtask
  task automatic t_bad(input logic a, b, input logic [3:0] n1, m1, n2, m2);
    setup(a, b, 0, n1, m1, n2, m2, 4, 4);
    @(negedge clk_sys);
    chk({15'h0000, ok}, 16'h0000);
  endtask
  initial begin
    t_bypass(1);
    t_bypass(0);
    t_single(1, 16'h0010, 16'h0018);
    t_single(0, 16'h0014, 16'h0014);
    t_cascade(0, 1, 2, 0, 0, 16'h0028, 16'h0028);
    t_cascade(1, 0, 0, 1, 2, 16'h0020, 16'h0030);
    t_bad(1, 0, 0, 0, 0, 0);
    t_bad(0, 1, 2, 1, 0, 0);
    t_bad(0, 1, 0, 2, 0, 0);
    t_bad(0, 0, 0, 0, 1, 2);
    final_report();
  end
endmodule
bind ccd_divider ccd_divider_sva u_sva (.clk_sys, .rst, .clk_in, .high_cnt_1, .low_cnt_1, .high_cnt_2,
  .low_cnt_2, .bypass_1, .bypass_2, .duty_correction_disable, .clk_out, .ratio, .config_ok);
